// [hw/llc_cmd_pkg.sv]
package llc_cmd_pkg;

  // Command opcodes seen in the command word
  localparam logic [15:0] OP_READ_ADAPTER = 16'h000B;
  localparam logic [15:0] OP_MODIFY_OPTS = 16'h000D;
  localparam logic [15:0] OP_RESTORE_OPTS = 16'h000E;
  localparam logic [15:0] OP_LINK_RESET = 16'h0014;
  localparam logic [15:0] OP_SP_OPEN = 16'h0015;

  // Completion codes
  localparam logic [15:0] CC_GOOD_HI = 16'h8000;
  localparam logic [15:0] CC_GOOD_LO = 16'h0000;
  localparam logic [15:0] CC_BAD_STATION = 16'h0040;
  localparam logic [15:0] CC_GROUP_FAIL_A = 16'h0045;
  localparam logic [15:0] CC_GROUP_FAIL_B = 16'h0049;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // Field positions and reset values
  localparam int WRAP_BIT = 0;
  localparam int PTR_HI_MSB = 7;
  localparam logic [15:0] OPTIONS_RESET = 16'h0000;
  localparam logic [7:0] SAP_ALL_LOW = 8'h00;

  // Link reset scope codes
  localparam logic [1:0] SCOPE_STATION = 2'h1;
  localparam logic [1:0] SCOPE_SAP = 2'h2;
  localparam logic [1:0] SCOPE_ALL = 2'h3;
  localparam logic [1:0] SCOPE_NONE = 2'h0;

  // Handler states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_REPLY = 4'b0100,
    ST_IRQ = 4'b1000
  } state_e;

  // Host command block
  typedef struct packed {
    logic [15:0] opcode;
    logic [15:0] param_first;
    logic [15:0] param_second;
  } cmd_s;

  // Status block written back to the host
  typedef struct packed {
    logic [15:0] opcode;
    logic [15:0] param_first;
    logic [15:0] param_second;
    logic [15:0] param_third;
  } reply_s;

endpackage : llc_cmd_pkg

// [hw/adapter_llc_command_handler.sv]
// Operation
// - Memory read done: reply 000B and code 8000, then interrupt.
// - Modify-options replaces open options; wrap bit 0 is ignored.
// - Option word comes in first parameter; second parameter is ignored.
// - Modify-options done: reply opcode 000D, code 8000, then interrupt.
// - Restore-options 000E: options in first parameter, bit 0 ignored.
// - Restore-options done: reply opcode 000E, code 8000, then interrupt.
// - Option commands are rejected while the adapter is not open.
// - Link reset 0014 ends outstanding work of the station or service point.
// - Global link reset returns to the state right after adapter open.
// - Link reset rejected when adapter closed or link control disabled.
// - Identifier xx00 resets a service point; 0000 resets everything.
// - Link reset done: opcode 0014, code 0000 or 0040, identifier echoed.
// - Service-point open 0015 activates from the host parameter block.
// - Service-point open rejected if adapter closed or link control off.
// - Block pointer is 24 bits over two parameters; top byte ignored.
// - Open done: 0015, station in second word, failing group on 0045/0049.
`timescale 1ns/10ps
`default_nettype none
module adapter_llc_command_handler (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // Host command block
  input wire logic CMD_VALID,
  input wire llc_cmd_pkg::cmd_s CMD,
  // Adapter state
  input wire logic ADAPTER_OPEN,
  input wire logic LLC_ENABLE,
  input wire logic OPEN_LOAD,
  input wire logic [15:0] OPEN_OPTIONS_IN,
  // Memory read engine
  output logic READ_START,
  input wire logic READ_DONE,
  // Link station reset engine
  output logic LRST_START,
  output logic [1:0] LRST_SCOPE,
  output logic [15:0] LRST_STATION,
  input wire logic LRST_DONE,
  input wire logic LRST_BAD,
  // Service-point open engine
  output logic SP_START,
  output logic [23:0] SP_BLOCK_PTR,
  input wire logic SP_DONE,
  input wire logic [15:0] SP_STATUS,
  input wire logic [15:0] SP_STATION,
  input wire logic [15:0] SP_FAIL_GROUP,
  // Results
  output logic [15:0] OPTIONS,
  output llc_cmd_pkg::reply_s REPLY,
  output logic REPLY_WRITE,
  output logic STATUS_IRQ,
  output logic CMD_REJECT,
  output logic BUSY
);

  llc_cmd_pkg::state_e state_reg, state_next;
  llc_cmd_pkg::cmd_s cmd_reg, cmd_next;
  llc_cmd_pkg::reply_s reply_reg, reply_next;
  logic [15:0] opts_reg, opts_next;
  logic [15:0] saved_reg, saved_next;
  logic read_reg, read_next;
  logic lrst_reg, lrst_next;
  logic [1:0] scope_reg, scope_next;
  logic sp_reg, sp_next;
  logic [23:0] ptr_reg, ptr_next;
  logic wr_reg, wr_next;
  logic irq_reg, irq_next;
  logic rej_reg, rej_next;
  logic busy_reg, busy_next;
  logic llc_ok;
  assign llc_ok = ADAPTER_OPEN && LLC_ENABLE;
  // Command decode, completion and reply building
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    reply_next = reply_reg;
    opts_next = opts_reg;
    saved_next = saved_reg;
    read_next = 1'b0;
    lrst_next = 1'b0;
    scope_next = scope_reg;
    sp_next = 1'b0;
    ptr_next = ptr_reg;
    wr_next = 1'b0;
    irq_next = 1'b0;
    rej_next = 1'b0;
    if (OPEN_LOAD) begin
      saved_next = OPEN_OPTIONS_IN;
      opts_next = OPEN_OPTIONS_IN;
    end
    case (state_reg)
      llc_cmd_pkg::ST_IDLE: begin
        if (CMD_VALID) begin
          cmd_next = CMD;
          case (CMD.opcode)
            llc_cmd_pkg::OP_READ_ADAPTER: begin
              read_next = 1'b1;
              state_next = llc_cmd_pkg::ST_WAIT;
            end
            llc_cmd_pkg::OP_MODIFY_OPTS,
            llc_cmd_pkg::OP_RESTORE_OPTS: begin
              if (!ADAPTER_OPEN) begin
                rej_next = 1'b1;
              end else begin
                // Keep wrap bit; second parameter unused
                opts_next = {CMD.param_first[15:1],
                  opts_reg[llc_cmd_pkg::WRAP_BIT]};
                state_next = llc_cmd_pkg::ST_REPLY;
              end
            end
            llc_cmd_pkg::OP_LINK_RESET: begin
              if (!llc_ok) begin
                rej_next = 1'b1;
              end else begin
                lrst_next = 1'b1;
                if (CMD.param_first == llc_cmd_pkg::WORD_ZERO) begin
                  scope_next = llc_cmd_pkg::SCOPE_ALL;
                end else if (CMD.param_first[7:0] ==
                             llc_cmd_pkg::SAP_ALL_LOW) begin
                  scope_next = llc_cmd_pkg::SCOPE_SAP;
                end else begin
                  scope_next = llc_cmd_pkg::SCOPE_STATION;
                end
                state_next = llc_cmd_pkg::ST_WAIT;
              end
            end
            llc_cmd_pkg::OP_SP_OPEN: begin
              if (!llc_ok) begin
                rej_next = 1'b1;
              end else begin
                sp_next = 1'b1;
                ptr_next = {CMD.param_first[llc_cmd_pkg::PTR_HI_MSB:0],
                            CMD.param_second};
                state_next = llc_cmd_pkg::ST_WAIT;
              end
            end
            default: begin
              rej_next = 1'b1;
            end
          endcase
        end
      end
      llc_cmd_pkg::ST_WAIT: begin
        case (cmd_reg.opcode)
          llc_cmd_pkg::OP_READ_ADAPTER: begin
            if (READ_DONE) begin
              state_next = llc_cmd_pkg::ST_REPLY;
            end
          end
          llc_cmd_pkg::OP_LINK_RESET: begin
            if (LRST_DONE) begin
              state_next = llc_cmd_pkg::ST_REPLY;
              reply_next.param_first = LRST_BAD ?
                llc_cmd_pkg::CC_BAD_STATION : llc_cmd_pkg::CC_GOOD_LO;
              reply_next.param_second = cmd_reg.param_first;
              reply_next.param_third = llc_cmd_pkg::WORD_ZERO;
              if (scope_reg == llc_cmd_pkg::SCOPE_ALL && !LRST_BAD) begin
                opts_next = saved_reg;
              end
            end
          end
          default: begin
            if (SP_DONE) begin
              state_next = llc_cmd_pkg::ST_REPLY;
              reply_next.param_first = SP_STATUS;
              reply_next.param_second = SP_STATION;
              reply_next.param_third =
                (SP_STATUS == llc_cmd_pkg::CC_GROUP_FAIL_A ||
                 SP_STATUS == llc_cmd_pkg::CC_GROUP_FAIL_B) ?
                SP_FAIL_GROUP : llc_cmd_pkg::WORD_ZERO;
            end
          end
        endcase
      end
      llc_cmd_pkg::ST_REPLY: begin
        // Whole status block written in one cycle ahead of the interrupt
        wr_next = 1'b1;
        reply_next.opcode = cmd_reg.opcode;
        // Link reset and service-point open filled their words when the engine answered
        if (cmd_reg.opcode != llc_cmd_pkg::OP_LINK_RESET &&
            cmd_reg.opcode != llc_cmd_pkg::OP_SP_OPEN) begin
          reply_next.param_first = llc_cmd_pkg::CC_GOOD_HI;
          reply_next.param_second = llc_cmd_pkg::WORD_ZERO;
          reply_next.param_third = llc_cmd_pkg::WORD_ZERO;
        end
        state_next = llc_cmd_pkg::ST_IRQ;
      end
      llc_cmd_pkg::ST_IRQ: begin
        irq_next = 1'b1;
        state_next = llc_cmd_pkg::ST_IDLE;
      end
      default: begin
        state_next = llc_cmd_pkg::ST_IDLE;
      end
    endcase
    busy_next = (state_next != llc_cmd_pkg::ST_IDLE); // Busy until idle
  end
  // State registers
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= llc_cmd_pkg::ST_IDLE;
      cmd_reg <= '0;
      reply_reg <= '0;
      opts_reg <= llc_cmd_pkg::OPTIONS_RESET;
      saved_reg <= llc_cmd_pkg::OPTIONS_RESET;
      read_reg <= 1'b0;
      lrst_reg <= 1'b0;
      scope_reg <= llc_cmd_pkg::SCOPE_NONE;
      sp_reg <= 1'b0;
      ptr_reg <= '0;
      wr_reg <= 1'b0;
      irq_reg <= 1'b0;
      rej_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      reply_reg <= reply_next;
      opts_reg <= opts_next;
      saved_reg <= saved_next;
      read_reg <= read_next;
      lrst_reg <= lrst_next;
      scope_reg <= scope_next;
      sp_reg <= sp_next;
      ptr_reg <= ptr_next;
      wr_reg <= wr_next;
      irq_reg <= irq_next;
      rej_reg <= rej_next;
      busy_reg <= busy_next;
    end
  end
  // Outputs straight from flops
  assign READ_START = read_reg;
  assign LRST_START = lrst_reg;
  assign LRST_SCOPE = scope_reg;
  assign LRST_STATION = cmd_reg.param_first;
  assign SP_START = sp_reg;
  assign SP_BLOCK_PTR = ptr_reg;
  assign OPTIONS = opts_reg;
  assign REPLY = reply_reg;
  assign REPLY_WRITE = wr_reg;
  assign STATUS_IRQ = irq_reg;
  assign CMD_REJECT = rej_reg;
  assign BUSY = busy_reg;
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  a_irq_after_write: assert property (
    STATUS_IRQ |-> $past(REPLY_WRITE))
    else $error("Interrupt without reply written the cycle before");
  a_read_reply: assert property (
    (STATUS_IRQ && REPLY.opcode == llc_cmd_pkg::OP_READ_ADAPTER) |->
    REPLY.param_first == llc_cmd_pkg::CC_GOOD_HI)
    else $error("Read completion code wrong");
  a_wrap_kept: assert property (
    (CMD_VALID && !BUSY && ADAPTER_OPEN && !OPEN_LOAD &&
     CMD.opcode == llc_cmd_pkg::OP_MODIFY_OPTS) |=>
    OPTIONS[0] == $past(OPTIONS[0]) &&
    OPTIONS[15:1] == $past(CMD.param_first[15:1]))
    else $error("Option update wrong");
  a_opts_reject: assert property (
    (CMD_VALID && !BUSY && !ADAPTER_OPEN &&
     CMD.opcode == llc_cmd_pkg::OP_RESTORE_OPTS) |=> CMD_REJECT && !BUSY)
    else $error("Closed adapter did not reject option command");
  a_reset_reject: assert property (
    (CMD_VALID && !BUSY && !llc_ok &&
     CMD.opcode == llc_cmd_pkg::OP_LINK_RESET) |=> CMD_REJECT && !LRST_START)
    else $error("Link reset not rejected");
  a_sp_reject: assert property (
    (CMD_VALID && !BUSY && !llc_ok &&
     CMD.opcode == llc_cmd_pkg::OP_SP_OPEN) |=> CMD_REJECT && !SP_START)
    else $error("Service-point open not rejected");
  a_scope_all: assert property (
    (CMD_VALID && !BUSY && llc_ok && CMD.param_first == 16'h0000 &&
     CMD.opcode == llc_cmd_pkg::OP_LINK_RESET) |=>
    LRST_START && LRST_SCOPE == llc_cmd_pkg::SCOPE_ALL)
    else $error("Global link reset scope wrong");
  a_reset_echo: assert property (
    (STATUS_IRQ && REPLY.opcode == llc_cmd_pkg::OP_LINK_RESET) |->
    REPLY.param_second == LRST_STATION && REPLY.param_third == 16'h0000)
    else $error("Link reset reply wrong");
  a_ptr_split: assert property (
    SP_START |-> SP_BLOCK_PTR == {$past(CMD.param_first[7:0]),
                                  $past(CMD.param_second)})
    else $error("Block pointer wrong");
  a_sp_group: assert property (
    (STATUS_IRQ && REPLY.opcode == llc_cmd_pkg::OP_SP_OPEN &&
     REPLY.param_first != 16'h0045 && REPLY.param_first != 16'h0049) |->
    REPLY.param_third == 16'h0000)
    else $error("Failing group reported without group failure");
  c_read_done: cover property (READ_START ##[1:20] STATUS_IRQ);
  c_reset_all: cover property (LRST_START && LRST_SCOPE ==
                               llc_cmd_pkg::SCOPE_ALL ##[1:20] STATUS_IRQ);
  c_sp_open: cover property (SP_START ##[1:20] STATUS_IRQ);
  c_reject: cover property (CMD_REJECT);
endmodule : adapter_llc_command_handler
`default_nettype wire

// [tb/llc_engine_model.sv]
`timescale 1ns/10ps
`default_nettype none
module llc_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Start requests from the handler
  input wire logic read_start,
  input wire logic lrst_start,
  input wire logic sp_start,
  // Behaviour chosen by the bench
  input wire logic [3:0] lat,
  input wire logic bad_in,
  input wire logic [15:0] sts_in,
  input wire logic [15:0] stn_in,
  input wire logic [15:0] grp_in,
  // Answers to the handler
  output logic read_done,
  output logic lrst_done,
  output logic lrst_bad,
  output logic sp_done,
  output logic [15:0] sp_status,
  output logic [15:0] sp_station,
  output logic [15:0] sp_fail_group
);
  logic [4:0] cnt_reg;
  logic [1:0] kind_reg;
  logic fire;

  // Latency counter, reloaded by any start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 5'h00;
      kind_reg <= 2'h0;
    end else if (read_start || lrst_start || sp_start) begin
      cnt_reg <= {1'b0, lat} + 5'h01;
      kind_reg <= read_start ? 2'h1 : (lrst_start ? 2'h2 : 2'h3);
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end

  // Done pulses; result lines show inverted junk outside the pulse
  assign fire = (cnt_reg == 5'h01);
  assign read_done = fire && (kind_reg == 2'h1);
  assign lrst_done = fire && (kind_reg == 2'h2);
  assign sp_done = fire && (kind_reg == 2'h3);
  assign lrst_bad = fire ? bad_in : ~bad_in;
  assign sp_status = fire ? sts_in : ~sts_in;
  assign sp_station = fire ? stn_in : ~stn_in;
  assign sp_fail_group = fire ? grp_in : ~grp_in;
endmodule : llc_engine_model
`default_nettype wire

// [tb/adapter_llc_command_handler_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module adapter_llc_command_handler_tb;
  logic MCLK, RESETN, CMD_VALID, ADAPTER_OPEN, LLC_ENABLE, OPEN_LOAD, bad;
  logic READ_START, READ_DONE, LRST_START, LRST_DONE, LRST_BAD, SP_START;
  logic SP_DONE, REPLY_WRITE, STATUS_IRQ, CMD_REJECT, BUSY;
  logic [15:0] OPEN_OPTIONS_IN, OPTIONS, LRST_STATION, SP_STATUS;
  logic [15:0] SP_STATION, SP_FAIL_GROUP, sts, stn, grp, saved, cur, op, p0, p1;
  logic [1:0] LRST_SCOPE;
  logic [23:0] SP_BLOCK_PTR;
  logic [3:0] lat;
  llc_cmd_pkg::cmd_s CMD;
  llc_cmd_pkg::reply_s REPLY;
  int failures, check_count;
  logic [15:0] rej_ops [5] = '{llc_cmd_pkg::OP_MODIFY_OPTS,
    llc_cmd_pkg::OP_RESTORE_OPTS, llc_cmd_pkg::OP_LINK_RESET,
    llc_cmd_pkg::OP_SP_OPEN, 16'h0007};

  adapter_llc_command_handler adapter_llc_command_handler_i (
    .MCLK(MCLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .ADAPTER_OPEN(ADAPTER_OPEN), .LLC_ENABLE(LLC_ENABLE),
    .OPEN_LOAD(OPEN_LOAD), .OPEN_OPTIONS_IN(OPEN_OPTIONS_IN),
    .READ_START(READ_START), .READ_DONE(READ_DONE),
    .LRST_START(LRST_START), .LRST_SCOPE(LRST_SCOPE),
    .LRST_STATION(LRST_STATION), .LRST_DONE(LRST_DONE), .LRST_BAD(LRST_BAD),
    .SP_START(SP_START), .SP_BLOCK_PTR(SP_BLOCK_PTR), .SP_DONE(SP_DONE),
    .SP_STATUS(SP_STATUS), .SP_STATION(SP_STATION),
    .SP_FAIL_GROUP(SP_FAIL_GROUP), .OPTIONS(OPTIONS), .REPLY(REPLY),
    .REPLY_WRITE(REPLY_WRITE), .STATUS_IRQ(STATUS_IRQ),
    .CMD_REJECT(CMD_REJECT), .BUSY(BUSY));

  llc_engine_model llc_engine_model_i (
    .clk(MCLK), .rst_n(RESETN), .read_start(READ_START),
    .lrst_start(LRST_START), .sp_start(SP_START), .lat(lat), .bad_in(bad),
    .sts_in(sts), .stn_in(stn), .grp_in(grp), .read_done(READ_DONE),
    .lrst_done(LRST_DONE), .lrst_bad(LRST_BAD), .sp_done(SP_DONE),
    .sp_status(SP_STATUS), .sp_station(SP_STATION),
    .sp_fail_group(SP_FAIL_GROUP));

  // Expected values
  function automatic logic [15:0] rnd();
    return 16'($urandom);
  endfunction : rnd
  function automatic logic [1:0] scope_of(input logic [15:0] id);
    if (id == 16'h0000) return 2'h3;
    return (id[7:0] == 8'h00) ? 2'h2 : 2'h1;
  endfunction : scope_of

  task automatic summarize();
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  // One command pulse; the host waits for the answer before the next
  task automatic issue(input logic [15:0] o, a, b);
    @(negedge MCLK);
    CMD_VALID = 1'b1;
    CMD = {o, a, b};
    @(negedge MCLK);
    CMD_VALID = 1'b0;
    CMD = ~CMD;
  endtask : issue

  task automatic reject(input logic [15:0] o);
    issue(o, rnd(), rnd());
    `CHK(CMD_REJECT, 1'b1)
    `CHK(BUSY, 1'b0)
    @(negedge MCLK);
    `CHK(REPLY_WRITE, 1'b0)
  endtask : reject

  task automatic reply(input llc_cmd_pkg::reply_s exp);
    int n;
    n = 0;
    while (REPLY_WRITE !== 1'b1) begin
      @(negedge MCLK);
      n++;
      if (n > 60) begin
        failures++;
        $display("Error %0t: reply never came", $time);
        summarize();
      end
    end
    `CHK(REPLY, exp)
    `CHK(STATUS_IRQ, 1'b0)
    `CHK(BUSY, 1'b1)
    @(negedge MCLK);
    `CHK(STATUS_IRQ, 1'b1)
    `CHK(BUSY, 1'b0)
  endtask : reply

  // Clock
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // Main sequence
  initial begin
    RESETN = 1'b0; CMD_VALID = 1'b0; CMD = '0; ADAPTER_OPEN = 1'b0;
    LLC_ENABLE = 1'b0; OPEN_LOAD = 1'b0; OPEN_OPTIONS_IN = '0; bad = 1'b0;
    lat = 4'h0; sts = '0; stn = '0; grp = '0; failures = 0; check_count = 0;
    void'($urandom(32'h1faf));
    repeat (20) @(negedge MCLK);
    RESETN = 1'b1;
    `CHK(OPTIONS, llc_cmd_pkg::OPTIONS_RESET)
    // Closed adapter refuses all but the memory read
    foreach (rej_ops[i]) reject(rej_ops[i]);
    issue(llc_cmd_pkg::OP_READ_ADAPTER, rnd(), rnd());
    `CHK(READ_START, 1'b1)
    reply({llc_cmd_pkg::OP_READ_ADAPTER, llc_cmd_pkg::CC_GOOD_HI,
      llc_cmd_pkg::WORD_ZERO, llc_cmd_pkg::WORD_ZERO});
    // Adapter open with wrap bit set
    @(negedge MCLK);
    OPEN_OPTIONS_IN = rnd() | 16'h0001;
    saved = OPEN_OPTIONS_IN;
    OPEN_LOAD = 1'b1;
    @(negedge MCLK);
    OPEN_LOAD = 1'b0;
    OPEN_OPTIONS_IN = ~saved;
    ADAPTER_OPEN = 1'b1;
    `CHK(OPTIONS, saved)
    reject(llc_cmd_pkg::OP_LINK_RESET);
    reject(llc_cmd_pkg::OP_SP_OPEN);
    // Option rewrites, first one tries to clear the wrap bit
    cur = saved;
    for (int i = 0; i < 4; i++) begin
      op = i[0] ? llc_cmd_pkg::OP_RESTORE_OPTS : llc_cmd_pkg::OP_MODIFY_OPTS;
      p0 = (i == 0) ? 16'h0000 : rnd();
      issue(op, p0, rnd());
      cur = {p0[15:1], cur[0]};
      reply({op, llc_cmd_pkg::CC_GOOD_HI, llc_cmd_pkg::WORD_ZERO,
        llc_cmd_pkg::WORD_ZERO});
      `CHK(OPTIONS, cur)
    end
    // Link resets: station, service point, global, invalid station
    LLC_ENABLE = 1'b1;
    for (int i = 0; i < 4; i++) begin
      p0 = rnd() | 16'h8001;
      if (i == 1) p0[7:0] = 8'h00;
      if (i == 2) p0 = 16'h0000;
      bad = (i == 3);
      lat = 4'(i * 5);
      issue(llc_cmd_pkg::OP_LINK_RESET, p0, rnd());
      `CHK(LRST_START, 1'b1)
      reply({llc_cmd_pkg::OP_LINK_RESET, bad ? llc_cmd_pkg::CC_BAD_STATION :
        llc_cmd_pkg::CC_GOOD_LO, p0, llc_cmd_pkg::WORD_ZERO});
      `CHK(LRST_SCOPE, scope_of(p0))
      `CHK(LRST_STATION, p0)
      if (i == 2) `CHK(OPTIONS, saved)
    end
    // Service point opens: good and both group failures
    for (int i = 0; i < 3; i++) begin
      sts = (i == 0) ? llc_cmd_pkg::CC_GOOD_LO : ((i == 1) ?
        llc_cmd_pkg::CC_GROUP_FAIL_A : llc_cmd_pkg::CC_GROUP_FAIL_B);
      stn = rnd(); grp = rnd(); p0 = rnd(); p1 = rnd(); lat = 4'($urandom);
      issue(llc_cmd_pkg::OP_SP_OPEN, p0, p1);
      `CHK(SP_START, 1'b1)
      reply({llc_cmd_pkg::OP_SP_OPEN, sts, stn,
        (i == 0) ? llc_cmd_pkg::WORD_ZERO : grp});
      `CHK(SP_BLOCK_PTR, {p0[7:0], p1})
    end
    summarize();
  end
endmodule : adapter_llc_command_handler_tb
`default_nettype wire
